// ===== verilog/option_byte_config_store.sv
// Summary of operation
// - blank one-time parts present all configuration bits as zero until programmed.
// - store is two bytes, high and low, together configuring the whole chip.
// - option bytes are unmapped for the program; only reachable in programming mode.
// - programming mode only while the high programming voltage is detected.
// - each byte takes one write; later writes are refused.
// - mask variants take fixed values from the supplied code image.
// - stop with watchdog active allowed only if bit nine set and nmi high.
// - bit eight enables the low voltage detector.
// - bit seven blocks external read-out of program memory.
// - bit six selects oscillator, zero crystal or clock, one rc network.
// - bit three enables the nmi pin pull-up.
// - bit two enables the timer pin pull-up.
// - bit one selects hardware watchdog, zero leaves it to software.
// - bit zero enables the oscillator safeguard.
`timescale 1ns/10ps
`default_nettype none
`include "option_store_regs.svh"

module option_byte_config_store (
    input wire logic clk,
    input wire logic rst,
    input wire logic vpp_high_pin,
    input wire logic mask_variant,
    input wire logic [15:0] mask_image,
    input wire option_store_pkg::prog_req_s prog_req,
    input wire logic prog_rd_sel_high,
    input wire logic nmi_pin,
    input wire logic watchdog_active,
    output logic [7:0] prog_rd_data,
    output logic prog_ack,
    output logic prog_reject,
    output logic prog_mode_out,
    output option_store_pkg::option_cfg_s cfg,
    output logic stop_allowed,
    output logic cfg_valid,
    output logic reserved_fault
);
    import option_store_pkg::*;

    logic prog_mode;
    logic [7:0] lo_rd;
    logic [7:0] hi_rd;
    logic lo_burnt;
    logic hi_burnt;
    prog_state_e state_reg;
    prog_state_e state_next;
    logic [1:0] load_cnt_reg;
    option_cfg_s cfg_reg;
    logic cfg_valid_reg;
    logic ack_reg;
    logic reject_reg;
    logic [7:0] rd_reg;
    logic stop_reg;
    logic mode_reg;
    logic rsv_fault_reg;
    logic nmi_s1_reg;
    logic nmi_s2_reg;
    logic nmi_s3_reg;
    logic nmi_level_reg;

    // decode one option word into the configuration controls
    function automatic option_cfg_s decode_word(input logic [15:0] w);
        option_cfg_s c;
        c.ext_stop_control = w[`OPT_BIT_EXT_STOP];
        c.low_voltage_detect_enable = w[`OPT_BIT_LVD];
        c.readout_protect = w[`OPT_BIT_PROTECT];
        c.osc_type = w[`OPT_BIT_OSC_RC] ? osc_rc : osc_crystal;
        c.nmi_pin_pullup_enable = w[`OPT_BIT_NMI_PULL];
        c.timer_pin_pullup_enable = w[`OPT_BIT_TIMER_PIN_PULLUP_ENABLE];
        c.watchdog_hw_select = w[`OPT_BIT_WDG_HW];
        c.clock_safeguard_enable = w[`OPT_BIT_SAFEGUARD];
        return c;
    endfunction : decode_word

    // write strobes only exist in programming mode; no program-side path exists
    wire req_ok = prog_req.valid && prog_mode;
    wire lo_wr = req_ok && !prog_req.sel_high && !lo_burnt && !mask_variant;
    wire hi_wr = req_ok && prog_req.sel_high && !hi_burnt && !mask_variant;
    wire req_refused = prog_req.valid && !(lo_wr || hi_wr);
    wire [15:0] stored_word = {hi_rd, lo_rd};
    // reserved-bit check on the written byte only, reported but not enforced;
    // the other byte may still be blank, so its lanes are masked out
    wire [15:0] prop_word = prog_req.sel_high ? {prog_req.data, 8'h00} : {8'h00, prog_req.data};
    wire [15:0] lane_mask = prog_req.sel_high ? 16'hff00 : 16'h00ff;
    wire [15:0] rsv_one = `OPT_RSV_ONE_MASK & lane_mask;
    wire rsv_bad = ((prop_word & `OPT_RSV_ZERO_MASK) != 16'h0000)
        || ((prop_word & rsv_one) != rsv_one);

    vpp_detect u_vpp (
        .clk(clk),
        .rst(rst),
        .vpp_high_pin(vpp_high_pin),
        .prog_mode(prog_mode)
    );

    option_byte_cell u_lo (
        .clk(clk),
        .rst(rst),
        .mask_value(mask_image[7:0]),
        .mask_variant(mask_variant),
        .prog_en(lo_wr),
        .prog_data(prog_req.data),
        .rd_data(lo_rd),
        .programmed(lo_burnt)
    );

    option_byte_cell u_hi (
        .clk(clk),
        .rst(rst),
        .mask_value(mask_image[15:8]),
        .mask_variant(mask_variant),
        .prog_en(hi_wr),
        .prog_data(prog_req.data),
        .rd_data(hi_rd),
        .programmed(hi_burnt)
    );

    // load sequence: wait for the registered cell reads to settle, then capture once
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_idle: state_next = st_check;
            st_check: begin
                if (load_cnt_reg == `OPT_LOAD_WAIT) begin
                    state_next = st_done;
                end
            end
            st_done: state_next = st_done;
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= st_idle;
            load_cnt_reg <= 2'd0;
        end else begin
            state_reg <= state_next;
            if (state_reg == st_check) begin
                load_cnt_reg <= load_cnt_reg + 2'd1;
            end
        end
    end

    // capture once; later programming only takes effect after the next reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= '0;
            cfg_valid_reg <= 1'b0;
        end else if (state_reg == st_check && state_next == st_done) begin
            cfg_reg <= decode_word(stored_word);
            cfg_valid_reg <= 1'b1;
        end
    end

    // nmi pin is asynchronous: three stages, accept on agreement of last two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_s1_reg <= 1'b0;
            nmi_s2_reg <= 1'b0;
            nmi_s3_reg <= 1'b0;
            nmi_level_reg <= 1'b0;
        end else begin
            nmi_s1_reg <= nmi_pin;
            nmi_s2_reg <= nmi_s1_reg;
            nmi_s3_reg <= nmi_s2_reg;
            if (nmi_s2_reg == nmi_s3_reg) begin
                nmi_level_reg <= nmi_s3_reg;
            end
        end
    end

    // stop gating: free when watchdog idle, else needs option and nmi high
    wire stop_ok = !watchdog_active
        || (cfg_reg.ext_stop_control && nmi_level_reg);

    // programmer port answers one cycle after the request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            reject_reg <= 1'b0;
            rd_reg <= 8'h00;
            stop_reg <= 1'b0;
            mode_reg <= 1'b0;
            rsv_fault_reg <= 1'b0;
        end else begin
            ack_reg <= lo_wr || hi_wr;
            reject_reg <= req_refused;
            rd_reg <= !prog_mode ? 8'h00 : (prog_rd_sel_high ? hi_rd : lo_rd);
            stop_reg <= cfg_valid_reg && stop_ok;
            mode_reg <= prog_mode;
            rsv_fault_reg <= (lo_wr || hi_wr) && rsv_bad;
        end
    end

    assign cfg = cfg_reg;
    assign cfg_valid = cfg_valid_reg;
    assign prog_ack = ack_reg;
    assign prog_reject = reject_reg;
    assign prog_rd_data = rd_reg;
    assign stop_allowed = stop_reg;
    assign prog_mode_out = mode_reg;
    assign reserved_fault = rsv_fault_reg;
endmodule : option_byte_config_store

`default_nettype wire

// ===== verilog/option_store_regs.svh
`ifndef OPTION_STORE_REGS_SVH
`define OPTION_STORE_REGS_SVH

// option word field positions
`define OPT_BIT_EXT_STOP 9
`define OPT_BIT_LVD 8
`define OPT_BIT_PROTECT 7
`define OPT_BIT_OSC_RC 6
`define OPT_BIT_RSV_SET 4
`define OPT_BIT_NMI_PULL 3
`define OPT_BIT_TIMER_PIN_PULLUP_ENABLE 2
`define OPT_BIT_WDG_HW 1
`define OPT_BIT_SAFEGUARD 0
// reserved bits that must be written as zero and as one
`define OPT_RSV_ZERO_MASK 16'hfc20
`define OPT_RSV_ONE_MASK 16'h0010
// blank part content
`define OPT_BLANK_VALUE 8'h00
// programming voltage detection threshold, millivolts, and sampled level width
`define OPT_VPP_MV 12500
`define OPT_VPP_FILTER_CYCLES 3
// settle cycles of the load sequence before the one-time capture
`define OPT_LOAD_WAIT 2'h2

`endif

// ===== verilog/option_store_pkg.sv
package option_store_pkg;

    typedef enum logic {
        osc_crystal,
        osc_rc
    } osc_type_e;

    // decoded configuration handed to the consuming units
    typedef struct packed {
        logic ext_stop_control;
        logic low_voltage_detect_enable;
        logic readout_protect;
        osc_type_e osc_type;
        logic nmi_pin_pullup_enable;
        logic timer_pin_pullup_enable;
        logic watchdog_hw_select;
        logic clock_safeguard_enable;
    } option_cfg_s;

    // programmer write request to one option byte
    typedef struct packed {
        logic valid;
        logic sel_high;
        logic [7:0] data;
    } prog_req_s;

    typedef enum logic [1:0] {
        st_idle,
        st_check,
        st_done
    } prog_state_e;

endpackage : option_store_pkg

// ===== verilog/option_byte_cell.sv
`timescale 1ns/10ps
`default_nettype none
`include "option_store_regs.svh"

// one-time-programmable byte: blank until the single write, then frozen
module option_byte_cell (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] mask_value,
    input wire logic mask_variant,
    input wire logic prog_en,
    input wire logic [7:0] prog_data,
    output logic [7:0] rd_data,
    output logic programmed
);
    logic [7:0] cell_reg;
    logic burnt_reg;
    logic [7:0] rd_reg;
    wire write_ok = prog_en && !burnt_reg && !mask_variant;

    // the cell models nonvolatile storage, so reset does not clear it in silicon;
    // here reset gives the blank state only because there is no power-up history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cell_reg <= `OPT_BLANK_VALUE;
            burnt_reg <= 1'b0;
        end else if (write_ok) begin
            cell_reg <= prog_data;
            burnt_reg <= 1'b1;
        end
    end

    // registered read port; mask parts read the fixed code image
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= mask_variant ? mask_value : cell_reg;
        end
    end

    assign rd_data = rd_reg;
    assign programmed = burnt_reg || mask_variant;
endmodule : option_byte_cell

`default_nettype wire

// ===== verilog/vpp_detect.sv
`timescale 1ns/10ps
`default_nettype none

// programming-voltage comparator output resynchronised; level accepted on agreement
module vpp_detect (
    input wire logic clk,
    input wire logic rst,
    input wire logic vpp_high_pin,
    output logic prog_mode
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic mode_reg;

    // three stages; only s2 and s3 are compared so s1 never feeds logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            s1_reg <= vpp_high_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                mode_reg <= s3_reg;
            end
        end
    end

    assign prog_mode = mode_reg;
endmodule : vpp_detect

`default_nettype wire

// ===== bench/config_store_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the option store; sees only the top module's ports
module config_store_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic vpp_high_pin,
    input wire logic mask_variant,
    input wire logic [15:0] mask_image,
    input wire option_store_pkg::prog_req_s prog_req,
    input wire logic nmi_pin,
    input wire logic watchdog_active,
    input wire logic [7:0] prog_rd_data,
    input wire logic prog_ack,
    input wire logic prog_reject,
    input wire logic prog_mode_out,
    input wire option_store_pkg::option_cfg_s cfg,
    input wire logic stop_allowed,
    input wire logic cfg_valid
);
    import option_store_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // every write gets exactly one answer, one cycle later
    a_one_answer: assert property (prog_req.valid |=> prog_ack != prog_reject)
        else $error("write without single answer");
    a_mask_refuse: assert property (prog_req.valid && mask_variant |=> prog_reject)
        else $error("mask part accepted a write");
    a_ack_in_mode: assert property (prog_ack |-> prog_mode_out)
        else $error("write accepted outside programming mode");
    a_vpp_entry: assert property (vpp_high_pin [*6] |=> prog_mode_out)
        else $error("programming voltage not recognised");
    // three cycles out of mode is past the two-stage read pipe
    a_rd_blank: assert property (!prog_mode_out && !$past(prog_mode_out)
        && !$past(prog_mode_out, 2) |-> prog_rd_data == 8'h00)
        else $error("option byte visible outside programming mode");
    a_cfg_hold: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg))
        else $error("configuration changed while valid");
    a_cfg_sticky: assert property (cfg_valid |=> cfg_valid)
        else $error("configuration valid dropped");
    a_mask_decode: assert property (mask_variant && cfg_valid
        |-> cfg == {mask_image[9:6], mask_image[3:0]})
        else $error("configuration differs from mask image");
    a_stop_block: assert property (cfg_valid && $past(cfg_valid, 3)
        && !cfg.ext_stop_control && watchdog_active && $past(watchdog_active)
        |-> !stop_allowed)
        else $error("stop allowed with watchdog active");
endmodule : config_store_checker
bind option_byte_config_store config_store_checker u_chk (.clk(clk), .rst(rst),
    .vpp_high_pin(vpp_high_pin), .mask_variant(mask_variant), .mask_image(mask_image),
    .prog_req(prog_req), .nmi_pin(nmi_pin), .watchdog_active(watchdog_active),
    .prog_rd_data(prog_rd_data), .prog_ack(prog_ack), .prog_reject(prog_reject),
    .prog_mode_out(prog_mode_out), .cfg(cfg), .stop_allowed(stop_allowed),
    .cfg_valid(cfg_valid));
`default_nettype wire

// ===== bench/prog_tool.sv
`timescale 1ns/10ps
`default_nettype none
// programmer model: owns the voltage pin and the byte write strobe
module prog_tool (
    input wire logic clk,
    output logic vpp_high_pin,
    output option_store_pkg::prog_req_s prog_req
);
    import option_store_pkg::*;
    initial begin
        vpp_high_pin = 1'b0;
        prog_req = '0;
    end
    task automatic set_vpp(input logic on);
        @(posedge clk);
        vpp_high_pin <= on;
    endtask : set_vpp
    // reserved bits are forced legal, so a careless caller cannot break them
    task automatic put(input logic hi, input logic [7:0] d);
        @(posedge clk);
        prog_req <= '{1'b1, hi, hi ? (d & 8'h03) : ((d & 8'hdf) | 8'h10)};
        @(posedge clk);
        prog_req.valid <= 1'b0;
    endtask : put
endmodule : prog_tool
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import option_store_pkg::*;
    logic clk = 1'b0, rst = 1'b1, mv = 1'b0, sel = 1'b0, nmi = 1'b0, wd = 1'b0;
    logic [15:0] image = 16'h0000;
    logic [15:0] img;
    logic vpp, ack, rej, mode, stop_ok, cfg_ok, rsv;
    logic [7:0] rd_data;
    prog_req_s req;
    option_cfg_s cfg;
    int n_mismatch = 0, cmp_count = 0;
    always #10 clk = ~clk;
    prog_tool u_prog_tool (.clk(clk), .vpp_high_pin(vpp), .prog_req(req));
    option_byte_config_store u_option_byte_config_store (.clk(clk), .rst(rst),
        .vpp_high_pin(vpp), .mask_variant(mv), .mask_image(image), .prog_req(req),
        .prog_rd_sel_high(sel), .nmi_pin(nmi), .watchdog_active(wd), .prog_rd_data(rd_data),
        .prog_ack(ack), .prog_reject(rej), .prog_mode_out(mode), .cfg(cfg),
        .stop_allowed(stop_ok), .cfg_valid(cfg_ok), .reserved_fault(rsv));
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : chk8
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // capture lands four edges after release; seven leaves stop_allowed settled too
    task automatic do_reset(input logic m, input logic [15:0] i);
        @(posedge clk);
        rst <= 1'b1;
        mv <= m;
        image <= i;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk1(cfg_ok, 1'b1);
    endtask : do_reset
    task automatic wr(input logic hi, input logic [7:0] d, input logic ok);
        u_prog_tool.put(hi, d);
        @(negedge clk);
        chk1(ack, ok);
        chk1(rej, !ok);
        chk1(rsv, 1'b0);
    endtask : wr
    task automatic rd(input logic hi, input logic [7:0] exp);
        @(posedge clk);
        sel <= hi;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk8(rd_data, exp);
    endtask : rd
    task automatic vpp_to(input logic on);
        u_prog_tool.set_vpp(on);
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk1(mode, on);
    endtask : vpp_to
    task automatic stop_chk(input logic w, input logic n, input logic exp);
        @(posedge clk);
        wd <= w;
        nmi <= n;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk1(stop_ok, exp);
    endtask : stop_chk
    initial begin
        do_reset(1'b0, 16'h0000);
        chk8(cfg, 8'h00);
        wr(1'b0, 8'h9b, 1'b0);
        vpp_to(1'b1);
        rd(1'b1, 8'h00);
        wr(1'b0, 8'h9b, 1'b1);
        rd(1'b0, 8'h9b);
        wr(1'b0, 8'h10, 1'b0);
        rd(1'b0, 8'h9b);
        wr(1'b1, 8'h03, 1'b1);
        wr(1'b1, 8'h00, 1'b0);
        rd(1'b1, 8'h03);
        chk8(cfg, 8'h00);
        vpp_to(1'b0);
        rd(1'b1, 8'h00);
        // mask parts: each option bit alone beside the reserved one
        for (int b = 0; b < 10; b++) begin
            if (b != 4 && b != 5) begin
                img = 16'h0010 | (16'h0001 << b);
                do_reset(1'b1, img);
                chk8(cfg, {img[9:6], img[3:0]});
            end
        end
        stop_chk(1'b1, 1'b1, 1'b1);
        stop_chk(1'b1, 1'b0, 1'b0);
        vpp_to(1'b1);
        wr(1'b0, 8'h10, 1'b0);
        do_reset(1'b1, 16'h0010);
        stop_chk(1'b1, 1'b1, 1'b0);
        stop_chk(1'b0, 1'b1, 1'b1);
        // high byte first while the low byte is still blank: no reserved fault
        do_reset(1'b0, 16'h0000);
        wr(1'b1, 8'h02, 1'b1);
        rd(1'b1, 8'h02);
        results();
    end
    // run needs about four hundred cycles; five thousand means a hang
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule : tb
`default_nettype wire
